// file: verilog/crcen_pkg.sv
// package: register map, field positions, reset values and carrier types for the crc engine
package crcen_pkg;
  // register word indices (byte address is four times the index)
  localparam logic [11:0] IDX_SCAN_LOW_ADDRESS  = 12'hF44;
  localparam logic [11:0] IDX_SCAN_HIGH_ADDRESS = 12'hF47;
  localparam logic [11:0] IDX_SCAN_CONTROL      = 12'hF4A;
  localparam logic [11:0] IDX_SCAN_TRIGGER      = 12'hF4B;
  localparam logic [11:0] IDX_CRC_DATA_WORD     = 12'hF6F;
  localparam logic [11:0] IDX_CRC_ACCUMULATOR   = 12'hF71;
  localparam logic [11:0] IDX_CRC_SHIFTER_VIEW  = 12'hF73;
  localparam logic [11:0] IDX_CRC_POLY_MASK     = 12'hF75;
  localparam logic [11:0] IDX_CRC_CONTROL       = 12'hF77;
  localparam logic [11:0] IDX_CRC_LENGTH_CONFIG = 12'hF78;
  // crc_control bit positions
  localparam int CTL_ENABLE     = 7;
  localparam int CTL_START      = 6;
  localparam int CTL_BUSY       = 5;
  localparam int CTL_ZERO_AUG   = 4;
  localparam int CTL_SHIFT_DIR  = 1;
  localparam int CTL_FULL       = 0;
  // crc_length_config field positions
  localparam int LEN_DATA_LSB   = 4;
  localparam int LEN_POLY_LSB   = 0;
  // scan_control bit positions
  localparam int SCN_ENABLE     = 7;
  localparam int SCN_REQUEST    = 6;
  // reset values
  localparam logic [7:0]  CTL_RESET      = 8'h00;
  localparam logic [7:0]  LEN_RESET      = 8'h00;
  localparam logic [15:0] ACC_RESET      = 16'h0000;
  localparam logic [15:0] POLY_BIT0      = 16'h0001;
  localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;
  // depth of the data holding buffer
  localparam int          BUF_DEPTH      = 2;
  // bus handshake states, gray along idle -> ack
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } crcen_bus_t;
  // engine configuration as steered by software
  typedef struct packed {
    logic       enable;
    logic       start;
    logic       zero_augment_select;
    logic       shift_direction;
    logic [3:0] data_word_length;
    logic [3:0] poly_length;
  } crcen_cfg_t;
  // word offered by the memory scanner
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } crcen_scan_t;
endpackage

// file: verilog/crcen_engine.sv
// module: programmable crc engine with avalon-mm register slave and scanner data port
//
// Overview of operation
// (R01) enable bit releases engine, zero holds inactive
// (R02) start bit runs shifter, zero stops shifting
// (R03) busy reads one while shifting or pending
// (R04) mode bit selects zero augmentation of data
// (R05) direction bit: one lsb first, zero msb first
// (R06) full reads one while holding word unconsumed
// (R07) data length field plus one bits per word
// (R08) poly length field plus one accumulator bits
// (R09) both control registers reset to zero
// (R10) data word register loaded by bytes
// (R11) accumulator bytes writable and readable directly
// (R12) polynomial mask bit zero always reads one
// (R13) scanner hands data only after ready
// (R14) one bit per cycle, xor poly on feedback
// (R15) full holding word moves into empty shifter
`timescale 1ns/10ps
module crcen_engine
(
  input  wire logic                 clk_sys,
  input  wire logic                 rstn,
  input  wire logic [11:0]          avs_address,
  input  wire logic                 avs_read,
  input  wire logic                 avs_write,
  input  wire logic [31:0]          avs_writedata,
  input  wire logic [3:0]           avs_byteenable,
  output logic      [31:0]          avs_readdata,
  output logic                      avs_waitrequest,
  input  wire crcen_pkg::crcen_scan_t scan_word,
  output logic                      crc_ready,
  output logic                      scan_request,
  output logic                      scanner_enable
);

  //////////////////////////////////////////////////////////////////////////////
  // state
  crcen_pkg::crcen_bus_t  bus_q;          // bus handshake state
  logic [31:0]            rdata_q;        // read data register
  logic                   wait_q;         // waitrequest register
  logic                   ready_q;        // ready towards scanner
  crcen_pkg::crcen_cfg_t  cfg_q;          // control and length fields
  logic [15:0]            stage_q;        // data word as last written or taken from the scanner
  logic [15:0]            acc_q;          // accumulator
  logic [15:0]            poly_q;         // polynomial mask, bit zero unused
  logic [15:0]            shift_q;        // serial shifter
  logic [4:0]             bits_q;         // bits still to shift
  logic [15:0]            buf_q [crcen_pkg::BUF_DEPTH]; // holding buffer
  logic                   rd_q;           // buffer read slot
  logic [1:0]             cnt_q;          // words held in buffer
  logic [23:0]            scan_lo_q;      // scan start address
  logic [23:0]            scan_hi_q;      // scan end address
  logic [7:0]             scan_ctl_q;     // scanner control
  logic [7:0]             scan_trig_q;    // scanner trigger select

  //////////////////////////////////////////////////////////////////////////////
  // decode
  logic        req;        // any request present
  logic        wr_ack;     // write takes effect this cycle
  logic        hit_data;   // request addresses the data word
  logic        scan_push;  // scanner word accepted
  logic        bus_push;   // bus word enters the buffer
  logic        load;       // buffer word moves into shifter
  logic        shifting;   // one bit moves this cycle
  logic        busy_w;     // live busy state
  logic [1:0]  cnt_d;      // next buffer count
  logic [15:0] data_merged; // data word with byte lanes applied
  logic [15:0] acc_merged;  // accumulator with byte lanes applied
  logic [15:0] acc_next;    // accumulator after one shift
  logic        din;         // data bit shifted out
  logic        fb;          // feedback bit
  logic [15:0] width_mask;  // accumulator width mask

  // merge the two low byte lanes of a write into a 16-bit value
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
    merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
  endfunction

  // register read mux; unmapped words read zero
  function automatic logic [31:0] read_mux(input logic [11:0] a);
    read_mux = crcen_pkg::RDATA_RESET;
    case (a)
      crcen_pkg::IDX_SCAN_LOW_ADDRESS:  read_mux = {8'h00, scan_lo_q};
      crcen_pkg::IDX_SCAN_HIGH_ADDRESS: read_mux = {8'h00, scan_hi_q};
      crcen_pkg::IDX_SCAN_CONTROL:      read_mux = {24'h000000, scan_ctl_q};
      crcen_pkg::IDX_SCAN_TRIGGER:      read_mux = {24'h000000, scan_trig_q};
      crcen_pkg::IDX_CRC_DATA_WORD:     read_mux = {16'h0000, stage_q};
      crcen_pkg::IDX_CRC_ACCUMULATOR:   read_mux = {16'h0000, acc_q};           // R11
      crcen_pkg::IDX_CRC_SHIFTER_VIEW:  read_mux = {16'h0000, shift_q};
      crcen_pkg::IDX_CRC_POLY_MASK:     read_mux = {16'h0000, poly_q | crcen_pkg::POLY_BIT0}; // R12
      crcen_pkg::IDX_CRC_CONTROL:
      begin
        read_mux[crcen_pkg::CTL_ENABLE]    = cfg_q.enable;
        read_mux[crcen_pkg::CTL_START]     = cfg_q.start;
        read_mux[crcen_pkg::CTL_BUSY]      = busy_w;                       // R03
        read_mux[crcen_pkg::CTL_ZERO_AUG]  = cfg_q.zero_augment_select;
        read_mux[crcen_pkg::CTL_SHIFT_DIR] = cfg_q.shift_direction;
        read_mux[crcen_pkg::CTL_FULL]      = (cnt_q != 2'd0);              // R06
      end
      crcen_pkg::IDX_CRC_LENGTH_CONFIG:
        read_mux = {24'h000000, cfg_q.data_word_length, cfg_q.poly_length};
      default:                          read_mux = crcen_pkg::RDATA_RESET;
    endcase
  endfunction

  // combinational decode of requests and buffer traffic
  always_comb
  begin
    req         = avs_read | avs_write;
    hit_data    = (avs_address == crcen_pkg::IDX_CRC_DATA_WORD);
    wr_ack      = avs_write & (bus_q == crcen_pkg::BUS_ACK);
    scan_push   = scan_word.valid & ready_q;                               // R13
    bus_push    = wr_ack & hit_data & cfg_q.enable;                        // R10
    load        = cfg_q.enable & cfg_q.start & (bits_q == 5'd0) & (cnt_q != 2'd0); // R15
    shifting    = cfg_q.enable & cfg_q.start & (bits_q != 5'd0);           // R02
    busy_w      = cfg_q.enable & ((bits_q != 5'd0) | (cnt_q != 2'd0));     // R03
    cnt_d       = cnt_q + {1'b0, scan_push | bus_push} - {1'b0, load};
    data_merged = merge16(stage_q, avs_writedata, avs_byteenable);
    acc_merged  = merge16(acc_q, avs_writedata, avs_byteenable);
  end

  // one shift step of the accumulator over the configured width
  always_comb
  begin
    width_mask = 16'hFFFF >> (4'hF - cfg_q.poly_length);                   // R08
    din        = cfg_q.shift_direction ? shift_q[0]                        // R05
                                       : shift_q[cfg_q.data_word_length];
    if (cfg_q.zero_augment_select)
    begin
      // augmented: data enters at the bottom, top bit alone is feedback
      fb       = acc_q[cfg_q.poly_length];                                 // R04
      acc_next = {acc_q[14:0], din};
    end
    else
    begin
      // direct: data joins the feedback, no augmenting zeros needed
      fb       = acc_q[cfg_q.poly_length] ^ din;                           // R04
      acc_next = {acc_q[14:0], 1'b0};
    end
    if (fb)
    begin
      acc_next = acc_next ^ (poly_q | crcen_pkg::POLY_BIT0);               // R14
    end
    acc_next = acc_next & width_mask;                                      // R14
  end

  //////////////////////////////////////////////////////////////////////////////
  // avalon-mm slave: one wait state, data writes stall while buffer is full

  // handshake state and waitrequest
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      bus_q  <= crcen_pkg::BUS_IDLE;
      wait_q <= 1'b1;
    end
    else
    begin
      case (bus_q)
        crcen_pkg::BUS_IDLE:
        begin
          // hold off a data write until the buffer has room
          if (req && !(avs_write && hit_data && cfg_q.enable &&
                       ({1'b0, cnt_q} + {2'b00, scan_push} >= 3'd2)))
          begin
            bus_q  <= crcen_pkg::BUS_ACK;
            wait_q <= 1'b0;
          end
        end
        crcen_pkg::BUS_ACK:
        begin
          bus_q  <= crcen_pkg::BUS_IDLE;
          wait_q <= 1'b1;
        end
        default:
        begin
          bus_q  <= crcen_pkg::BUS_IDLE;
          wait_q <= 1'b1;
        end
      endcase
    end
  end

  // read data captured as the answer is granted
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      rdata_q <= crcen_pkg::RDATA_RESET;
    end
    else if (bus_q == crcen_pkg::BUS_IDLE && avs_read)
    begin
      rdata_q <= read_mux(avs_address);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // software registers

  // control and length fields
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      cfg_q <= {crcen_pkg::CTL_RESET[7:6], crcen_pkg::CTL_RESET[4],        // R09
                crcen_pkg::CTL_RESET[1], crcen_pkg::LEN_RESET};
    end
    else if (wr_ack && avs_byteenable[0])
    begin
      if (avs_address == crcen_pkg::IDX_CRC_CONTROL)
      begin
        cfg_q.enable              <= avs_writedata[crcen_pkg::CTL_ENABLE]; // R01
        cfg_q.start               <= avs_writedata[crcen_pkg::CTL_START];  // R02
        cfg_q.zero_augment_select <= avs_writedata[crcen_pkg::CTL_ZERO_AUG];
        cfg_q.shift_direction     <= avs_writedata[crcen_pkg::CTL_SHIFT_DIR];
      end
      else if (avs_address == crcen_pkg::IDX_CRC_LENGTH_CONFIG)
      begin
        cfg_q.data_word_length <= avs_writedata[crcen_pkg::LEN_DATA_LSB +: 4]; // R07
        cfg_q.poly_length      <= avs_writedata[crcen_pkg::LEN_POLY_LSB +: 4]; // R08
      end
    end
  end

  // data word staging
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      stage_q <= crcen_pkg::ACC_RESET;
    end
    else if (wr_ack && hit_data)
    begin
      stage_q <= data_merged;                                              // R10
    end
    else if (scan_push)
    begin
      stage_q <= scan_word.data;                                           // R10
    end
  end

  // polynomial mask; own process so a scanner word cannot swallow a write
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      poly_q <= crcen_pkg::POLY_BIT0;
    end
    else if (wr_ack && avs_address == crcen_pkg::IDX_CRC_POLY_MASK)
    begin
      poly_q <= merge16(poly_q, avs_writedata, avs_byteenable);            // R12
    end
  end

  // scanner map: storage only, two bits steer the scanner
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      scan_lo_q   <= 24'h000000;
      scan_hi_q   <= 24'h000000;
      scan_ctl_q  <= 8'h00;
      scan_trig_q <= 8'h00;
    end
    else if (wr_ack)
    begin
      case (avs_address)
        crcen_pkg::IDX_SCAN_LOW_ADDRESS:
          scan_lo_q <= {avs_byteenable[2] ? avs_writedata[23:16] : scan_lo_q[23:16],
                        merge16(scan_lo_q[15:0], avs_writedata, avs_byteenable)};
        crcen_pkg::IDX_SCAN_HIGH_ADDRESS:
          scan_hi_q <= {avs_byteenable[2] ? avs_writedata[23:16] : scan_hi_q[23:16],
                        merge16(scan_hi_q[15:0], avs_writedata, avs_byteenable)};
        crcen_pkg::IDX_SCAN_CONTROL:
          if (avs_byteenable[0]) scan_ctl_q <= avs_writedata[7:0];
        crcen_pkg::IDX_SCAN_TRIGGER:
          if (avs_byteenable[0]) scan_trig_q <= avs_writedata[7:0];
        default:
          scan_ctl_q <= scan_ctl_q;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // data path: two-entry holding buffer, shifter, accumulator

  // holding buffer; cleared while disabled
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || !cfg_q.enable)
    begin
      cnt_q <= 2'd0;                                                       // R01
      rd_q  <= 1'b0;
    end
    else
    begin
      if (scan_push || bus_push)
      begin
        buf_q[rd_q ^ cnt_q[0]] <= scan_push ? scan_word.data : data_merged;
      end
      if (load)
      begin
        rd_q <= ~rd_q;                                                     // R06
      end
      cnt_q <= cnt_d;
    end
  end

  // ready to scanner: room for a word that no bus write will take
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      ready_q <= 1'b0;
    end
    else
    begin
      ready_q <= cfg_q.enable && scan_ctl_q[crcen_pkg::SCN_ENABLE] &&      // R13
                 (cnt_d < 2'd2) && !(bus_q == crcen_pkg::BUS_IDLE && avs_write && hit_data);
    end
  end

  // serial shifter and bit counter
  always_ff @(posedge clk_sys)
  begin
    if (!rstn || !cfg_q.enable)
    begin
      shift_q <= crcen_pkg::ACC_RESET;                                     // R01
      bits_q  <= 5'd0;
    end
    else if (load)
    begin
      shift_q <= buf_q[rd_q];                                              // R15
      bits_q  <= {1'b0, cfg_q.data_word_length} + 5'd1;                    // R07
    end
    else if (shifting)
    begin
      shift_q <= cfg_q.shift_direction ? {1'b0, shift_q[15:1]}             // R05
                                       : {shift_q[14:0], 1'b0};
      bits_q  <= bits_q - 5'd1;
    end
  end

  // accumulator: software byte writes win over a shift
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      acc_q <= crcen_pkg::ACC_RESET;
    end
    else if (wr_ack && avs_address == crcen_pkg::IDX_CRC_ACCUMULATOR)
    begin
      acc_q <= acc_merged;                                                 // R11
    end
    else if (shifting)
    begin
      acc_q <= acc_next;                                                   // R14
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs
  assign avs_readdata    = rdata_q;
  assign avs_waitrequest = wait_q;
  assign crc_ready       = ready_q;
  assign scan_request    = scan_ctl_q[crcen_pkg::SCN_REQUEST];
  assign scanner_enable  = scan_ctl_q[crcen_pkg::SCN_ENABLE];

  //////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_load;
    load;
  endsequence
  sequence s_ctrl_read;
    bus_q == crcen_pkg::BUS_IDLE && avs_read && avs_address == crcen_pkg::IDX_CRC_CONTROL;
  endsequence

  property p_disable_holds;
    !cfg_q.enable |=> (bits_q == 5'd0) && (cnt_q == 2'd0) && !crc_ready;
  endproperty
  a_disable_holds: assert property (p_disable_holds) else $error("disabled engine active"); // R01

  property p_stop_freezes;
    cfg_q.enable && !cfg_q.start |=> $stable(shift_q) && $stable(bits_q);
  endproperty
  a_stop_freezes: assert property (p_stop_freezes) else $error("shifter moved while stopped"); // R02

  property p_busy_read;
    s_ctrl_read ##0 (cfg_q.enable && bits_q != 5'd0) |=> avs_readdata[crcen_pkg::CTL_BUSY];
  endproperty
  a_busy_read: assert property (p_busy_read) else $error("busy read low while shifting"); // R03

  property p_full_read;
    s_ctrl_read |=> avs_readdata[crcen_pkg::CTL_FULL] == ($past(cnt_q) != 2'd0);
  endproperty
  a_full_read: assert property (p_full_read) else $error("full flag wrong"); // R06

  property p_load_len;
    s_load |=> bits_q == {1'b0, $past(cfg_q.data_word_length)} + 5'd1;
  endproperty
  a_load_len: assert property (p_load_len) else $error("bit count not length plus one"); // R07

  property p_word_drains;
    s_load ##1 (cfg_q.start && cfg_q.enable) [*2] |-> bits_q < $past(bits_q);
  endproperty
  a_word_drains: assert property (p_word_drains) else $error("shifter not counting down"); // R14

  property p_acc_width;
    shifting && !(wr_ack && avs_address == crcen_pkg::IDX_CRC_ACCUMULATOR)
      |=> (acc_q & ~(16'hFFFF >> (4'hF - $past(cfg_q.poly_length)))) == 16'h0000;
  endproperty
  a_acc_width: assert property (p_acc_width) else $error("accumulator exceeds width"); // R08

  property p_poly_bit0;
    bus_q == crcen_pkg::BUS_IDLE && avs_read && avs_address == crcen_pkg::IDX_CRC_POLY_MASK
      |=> avs_readdata[0] && !avs_waitrequest;
  endproperty
  a_poly_bit0: assert property (p_poly_bit0) else $error("poly bit zero read low"); // R12

  property p_shifter_fill;
    load |=> (bits_q != 5'd0) && (cnt_q == $past(cnt_q) - 2'd1 + {1'b0, $past(scan_push | bus_push)});
  endproperty
  a_shifter_fill: assert property (p_shifter_fill) else $error("holding word not moved"); // R15

  property p_acc_write;
    wr_ack && avs_address == crcen_pkg::IDX_CRC_ACCUMULATOR |=> acc_q == $past(acc_merged);
  endproperty
  a_acc_write: assert property (p_acc_write) else $error("accumulator byte write lost"); // R11

endmodule

// file: tb/crcen_scanner_model.sv
// memory scanner stand-in that offers words to the crc engine
`timescale 1ns/10ps
module crcen_scanner_model
(
  input  wire logic                   clk_sys,
  input  wire logic                   rstn,
  input  wire logic                   crc_ready,
  input  wire logic                   scan_request,
  input  wire logic                   scanner_enable,
  input  wire logic                   send,
  input  wire logic [15:0]            send_data,
  output crcen_pkg::crcen_scan_t      scan_word
);
  ////////////////////////////////////////////////////////////////////////////
  // offer one word, hold it until taken, then scramble the released data
  always_ff @(posedge clk_sys)
  begin
    if (!rstn)
    begin
      scan_word <= '0;
    end
    else if (scan_word.valid && crc_ready)
    begin
      // word taken: release the line, data no longer meaningful
      scan_word.valid <= 1'b0;
      scan_word.data  <= ~scan_word.data;
    end
    else if (!scan_word.valid && send && scan_request && scanner_enable)
    begin
      // only fetch while the scan is requested and enabled
      scan_word.valid <= 1'b1;
      scan_word.data  <= send_data;
    end
    else if (!scan_word.valid)
    begin
      scan_word.data <= ~scan_word.data;
    end
  end
endmodule

// file: tb/tb_crcen_engine.sv
// self-checking bench for the crc engine
`timescale 1ns/10ps
module tb_crcen_engine;
  logic                   clk_sys = 1'b0;
  logic                   rstn = 1'b0;
  logic [11:0]            avs_address = 12'h000;
  logic                   avs_read = 1'b0;
  logic                   avs_write = 1'b0;
  logic [31:0]            avs_writedata = 32'h0;
  logic [3:0]             avs_byteenable = 4'h0;
  logic [31:0]            avs_readdata;
  logic                   avs_waitrequest;
  crcen_pkg::crcen_scan_t scan_word;
  logic                   crc_ready;
  logic                   scan_request;
  logic                   scanner_enable;
  logic                   send = 1'b0;
  logic [15:0]            send_data = 16'h0;
  int                     bad_count = 0;
  int                     comparisons = 0;
  logic [15:0]            acc_exp;
  logic [31:0]            q;
  ////////////////////////////////////////////////////////////////////////////
  // clock and design under test
  always #20 clk_sys = ~clk_sys;
  crcen_engine i_dut (.clk_sys(clk_sys), .rstn(rstn), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scan_word(scan_word), .crc_ready(crc_ready),
    .scan_request(scan_request), .scanner_enable(scanner_enable));
  crcen_scanner_model i_scan (.clk_sys(clk_sys), .rstn(rstn), .crc_ready(crc_ready),
    .scan_request(scan_request), .scanner_enable(scanner_enable), .send(send),
    .send_data(send_data), .scan_word(scan_word));
  ////////////////////////////////////////////////////////////////////////////
  // verdict, comparison and bus tasks
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one avalon access, held until waitrequest is sampled low
  task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      input logic [3:0] be);
    @(posedge clk_sys);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    avs_byteenable <= be;
    // waitrequest sampled low ends this wait; with no count limit, otherwise only the watchdog does
    do
    begin
      @(posedge clk_sys);
    end
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, a, d, 4'hF);
  endtask
  task automatic rd(input string nm, input logic [11:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0, 4'hF);
    chk(nm, e, q);
  endtask
  // poll the control register until shifting has finished
  task automatic wait_idle();
    int n;
    n = 0;
    do
    begin
      xfer(1'b0, crcen_pkg::IDX_CRC_CONTROL, 32'h0, 4'hF);
      n++;
    end
    while (q[crcen_pkg::CTL_BUSY] !== 1'b0 && n < 50);
  endtask
  // hand one word to the scanner model, optionally wait until the engine took it
  task automatic push(input logic [15:0] d, input logic wait_take);
    int n;
    n = 0;
    @(posedge clk_sys);
    send <= 1'b1;
    send_data <= d;
    @(posedge clk_sys);
    send <= 1'b0;
    while (wait_take && !(scan_word.valid === 1'b1 && crc_ready === 1'b1) && n < 100)
    begin
      @(posedge clk_sys);
      n++;
    end
  endtask
  // reference crc step over one data word
  function automatic logic [15:0] crc_ref(input logic [15:0] a, input logic [15:0] p,
    input logic [15:0] d, input int dl, input int pl, input logic dir, input logic aug);
    logic        fb;
    logic        din;
    logic [15:0] m;
    m = 16'hFFFF >> (15 - pl);
    for (int i = 0; i <= dl; i++)
    begin
      din = dir ? d[i] : d[dl - i];
      fb = aug ? a[pl] : a[pl] ^ din;
      a = (a << 1) | (aug ? {15'h0, din} : 16'h0);
      if (fb)
        a = a ^ (p | 16'h0001);
      a = a & m;
    end
    return a;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // watchdog against a hang
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    give_verdict();
  end
  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (5) @(posedge clk_sys);
    rstn <= 1'b1;
    rd("ctl_reset", crcen_pkg::IDX_CRC_CONTROL, 32'h0);
    rd("len_reset", crcen_pkg::IDX_CRC_LENGTH_CONFIG, 32'h0);
    rd("poly_reset", crcen_pkg::IDX_CRC_POLY_MASK, 32'h1);
    rd("unmapped", 12'h100, 32'h0);
    wr(crcen_pkg::IDX_CRC_CONTROL, 32'hFF);
    rd("ctl_access", crcen_pkg::IDX_CRC_CONTROL, 32'hD2);
    wr(crcen_pkg::IDX_CRC_POLY_MASK, 32'h1020);
    rd("poly_bit0", crcen_pkg::IDX_CRC_POLY_MASK, 32'h1021);
    wr(crcen_pkg::IDX_CRC_ACCUMULATOR, 32'hBEEF);
    xfer(1'b1, crcen_pkg::IDX_CRC_ACCUMULATOR, 32'h12, 4'h1);
    rd("acc_low_byte", crcen_pkg::IDX_CRC_ACCUMULATOR, 32'hBE12);
    // every direction and augmentation mode, with varied lengths
    for (int i = 0; i < 4; i++)
    begin
      int dl;
      int pl;
      dl = (i == 2) ? 3 : ((i == 1) ? 7 : 15);
      pl = (i < 2) ? 15 : 7;
      wr(crcen_pkg::IDX_CRC_LENGTH_CONFIG, {24'h0, dl[3:0], pl[3:0]});
      wr(crcen_pkg::IDX_CRC_ACCUMULATOR, 32'h00A5);
      wr(crcen_pkg::IDX_CRC_CONTROL, {24'h0, 2'b11, 1'b0, i[1], 2'b00, i[0], 1'b0});
      wr(crcen_pkg::IDX_CRC_DATA_WORD, 32'hC3A9);
      if (i == 0)
        rd("busy_full", crcen_pkg::IDX_CRC_CONTROL, 32'hE0);
      wait_idle();
      acc_exp = crc_ref(16'h00A5, 16'h1021, 16'hC3A9, dl, pl, i[0], i[1]);
      rd("crc_mode", crcen_pkg::IDX_CRC_ACCUMULATOR, {16'h0, acc_exp});
    end
    // scanner fills the buffer while the shifter is stopped
    wr(crcen_pkg::IDX_CRC_LENGTH_CONFIG, 32'hFF);
    wr(crcen_pkg::IDX_CRC_POLY_MASK, 32'h8005);
    wr(crcen_pkg::IDX_CRC_ACCUMULATOR, 32'h0);
    wr(crcen_pkg::IDX_CRC_CONTROL, 32'h80);
    wr(crcen_pkg::IDX_SCAN_CONTROL, 32'hC0);
    push(16'h1234, 1'b1);
    chk("scan_outs", 32'h3, {30'h0, scanner_enable, scan_request});
    push(16'h5678, 1'b1);
    repeat (3) @(posedge clk_sys);
    chk("ready_full", 32'h0, {31'h0, crc_ready});
    rd("pending", crcen_pkg::IDX_CRC_CONTROL, 32'hA1);
    push(16'h9ABC, 1'b0);
    repeat (5) @(posedge clk_sys);
    chk("refused", 32'h1, {31'h0, scan_word.valid});
    rd("acc_held", crcen_pkg::IDX_CRC_ACCUMULATOR, 32'h0);
    wr(crcen_pkg::IDX_CRC_CONTROL, 32'hC0);
    repeat (60) @(posedge clk_sys);
    wait_idle();
    acc_exp = crc_ref(16'h0, 16'h8005, 16'h1234, 15, 15, 1'b0, 1'b0);
    acc_exp = crc_ref(acc_exp, 16'h8005, 16'h5678, 15, 15, 1'b0, 1'b0);
    acc_exp = crc_ref(acc_exp, 16'h8005, 16'h9ABC, 15, 15, 1'b0, 1'b0);
    rd("drained", crcen_pkg::IDX_CRC_ACCUMULATOR, {16'h0, acc_exp});
    rd("data_word", crcen_pkg::IDX_CRC_DATA_WORD, 32'h9ABC);
    // disabling drops a pending word, accumulator kept
    wr(crcen_pkg::IDX_CRC_CONTROL, 32'h80);
    wr(crcen_pkg::IDX_CRC_DATA_WORD, 32'h0F0F);
    wr(crcen_pkg::IDX_CRC_CONTROL, 32'h40);
    rd("disabled", crcen_pkg::IDX_CRC_CONTROL, 32'h40);
    wr(crcen_pkg::IDX_CRC_CONTROL, 32'hC0);
    repeat (30) @(posedge clk_sys);
    rd("acc_kept", crcen_pkg::IDX_CRC_ACCUMULATOR, {16'h0, acc_exp});
    give_verdict();
  end
endmodule
